// ### design/dtrc_pkg.sv
package dtrc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] DTRC_OFF_SCRATCH0 = 8'h00;
  localparam logic [7:0] DTRC_OFF_SCRATCH1 = 8'h04;
  localparam logic [7:0] DTRC_OFF_CONTROL = 8'h08;
  localparam logic [7:0] DTRC_OFF_CONFIG = 8'h0c;
  localparam logic [7:0] DTRC_OFF_STATUS = 8'h10;

  // Reset values.
  localparam logic [15:0] DTRC_RST_SCRATCH = 16'h0000;
  localparam logic [7:0] DTRC_RST_CONTROL = 8'h00;
  localparam logic [3:0] DTRC_RST_CMD = 4'h0;

  // Field positions of debug_control and of the configuration register.
  localparam int DTRC_BIT_BP_ENABLE = 7;
  localparam int DTRC_BIT_REG_BREAK = 5;
  localparam int DTRC_CMD_MSB = 3;
  localparam int DTRC_BIT_SWITCHBACK = 0;

  // Instruction pointer value on debug entry.
  localparam logic [15:0] DTRC_ENTRY_IP = 16'h8010;

  // Status codes presented to the host.
  localparam logic [1:0] DTRC_ST_NON_DEBUG = 2'h0;
  localparam logic [1:0] DTRC_ST_IDLE = 2'h1;
  localparam logic [1:0] DTRC_ST_BUSY = 2'h2;

  // Host debug opcodes.
  localparam logic [3:0] DTRC_OP_PREFIX = 4'h2;
  localparam logic [3:0] DTRC_OP_TRACE = 4'h6;
  localparam logic [3:0] DTRC_OP_RETURN = 4'h7;

  // Command code values loaded for the service routine.
  localparam logic [3:0] DTRC_CMD_NOP = 4'h0;
  localparam logic [3:0] DTRC_CMD_REGMAP = 4'h1;
  localparam logic [3:0] DTRC_CMD_MEM_RD = 4'h2;
  localparam logic [3:0] DTRC_CMD_STACK_RD = 4'h3;
  localparam logic [3:0] DTRC_CMD_REG_WR = 4'h4;
  localparam logic [3:0] DTRC_CMD_MEM_WR = 4'h5;
  localparam logic [3:0] DTRC_CMD_UNLOCK = 4'h8;
  localparam logic [3:0] DTRC_CMD_REG_RD = 4'h9;

  typedef enum logic [2:0] {
    DTRC_BACKGROUND,
    DTRC_ENTER,
    DTRC_DBG_IDLE,
    DTRC_ROM_BUSY,
    DTRC_TRACE_POP,
    DTRC_TRACE_EXEC,
    DTRC_RET_POP
  } dtrc_state_t;

endpackage : dtrc_pkg

// ### design/dtrc_bp_match.sv
`timescale 1ns/10ps
module dtrc_bp_match
  import dtrc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Gating.
  input wire logic bp_enable,
  input wire logic reg_break_enable,
  input wire logic suppress,
  input wire logic other_hit,
  // Destination write of the current instruction.
  input wire logic dest_wr,
  input wire logic [15:0] dest_addr,
  input wire logic [15:0] dest_data,
  // Breakpoint values.
  input wire logic [15:0] address_match_breakpoint,
  input wire logic [15:0] data_match_breakpoint,
  input wire logic [15:0] debug_address_hold,
  input wire logic [15:0] debug_data_hold,
  // Result.
  output logic break_hit
);

  logic break_hit_r;
  wire logic [15:0] diff_masked;
  wire logic addr_hit;
  wire logic data_hit;
  wire logic any_hit;

  assign diff_masked = (dest_data ^ debug_data_hold) & debug_address_hold;
  assign addr_hit = reg_break_enable & dest_wr & (dest_addr == address_match_breakpoint);
  assign data_hit = reg_break_enable & dest_wr & (dest_addr == data_match_breakpoint) &
                    (diff_masked == 16'h0000);
  assign any_hit = bp_enable & ~suppress & (addr_hit | data_hit | other_hit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_hit_r <= 1'b0;
    end else begin
      break_hit_r <= any_hit;
    end
  end

  assign break_hit = break_hit_r;

endmodule : dtrc_bp_match

// ### design/dtrc_top.sv
`timescale 1ns/10ps
// Contract
// - Trace: status busy, pop return address, restore interrupt enable, run that instruction.
// - After traced instruction: stall, block fetch, push, load entry address, halt, idle.
// - Instruction pointer advances during a step so the next address is pushed.
// - A pending interrupt may be granted during a step with restored enable.
// - Return: pop, restore interrupt enable, fetch, run user code, status non-debug.
// - No breakpoint on the first instruction after returning to background mode.
// - Returning to background mode re-enables all internal timers.
// - Switchback enabled in low-power clock forces divide-by-1 on debug entry.
// - Reset pin asserted after a halting register write resets engine to background.
// - While tracing, interrupt enable changes are overridden by the captured value.
// - Debug entry pushes one stack entry; a full stack loses its oldest.
// - Crystal warmup counter keeps running in debug; completion switches clock glitch-free.
// - System clock is stopped in debug mode between commands.
// - Setting low-power mode enable is ignored in the first instruction after return.
// - Scratch registers accessible only in background or debug mode; reset zero.
// - Breakpoint enable gates all breakpoints; changeable only in background debug mode.
// - Register break enable selects address and masked data match breakpoints.
// - Command code register loads service routine commands; trace and return leave it unchanged, others read as no-op.
// - Data match compares only bits whose mask bits are one.
module dtrc_top
  import dtrc_pkg::*;
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host command and TAP side.
  input wire logic host_cmd_valid,
  input wire logic [7:0] host_cmd_code,
  input wire logic debug_cmd_entry,
  input wire logic bg_debug_mode,
  input wire logic rom_done,
  input wire logic reset_pin,
  output logic [1:0] debug_status,
  // CPU side.
  input wire logic instr_done,
  input wire logic global_interrupt_enable,
  input wire logic low_power_clock_mode,
  input wire logic warmup_done,
  output logic stack_pop,
  output logic stack_push,
  output logic ip_load,
  output logic [15:0] instruction_pointer,
  output logic cpu_stall,
  output logic fetch_block,
  output logic cpu_halt,
  output logic gie_force,
  output logic gie_force_value,
  output logic lpm_enable_block,
  output logic timers_enable,
  output logic warmup_run,
  output logic clk_src_switch,
  output logic clk_div1_force,
  output logic sysclk_run,
  // Breakpoint sources.
  input wire logic dest_wr,
  input wire logic [15:0] dest_addr,
  input wire logic [15:0] dest_data,
  input wire logic other_bp_hit,
  input wire logic [15:0] address_match_breakpoint,
  input wire logic [15:0] data_match_breakpoint,
  input wire logic [15:0] debug_address_hold,
  input wire logic [15:0] debug_data_hold
);

  dtrc_state_t state_r;
  dtrc_state_t state_nxt;
  logic [15:0] scratch0_r;
  logic [15:0] scratch1_r;
  logic bp_enable_r;
  logic reg_break_r;
  logic [3:0] cmd_r;
  logic switchback_r;
  logic gie_saved_r;
  logic first_instr_r;
  logic rst_s1_r;
  logic rst_s2_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [1:0] status_r;
  logic pop_r;
  logic push_r;
  logic ip_load_r;
  logic stall_r;
  logic fetch_block_r;
  logic halt_r;
  logic gie_force_r;
  logic gie_val_r;
  logic lpm_block_r;
  logic timers_r;
  logic warmup_run_r;
  logic clk_switch_r;
  logic div1_r;
  logic sysclk_r;
  logic [3:0] cmd_nxt;
  logic [1:0] status_nxt;
  logic break_hit;

  wire logic setup_ph = psel & ~penable;
  wire logic wr_en = psel & penable & pwrite & pready_r;
  wire logic sel_scr0 = (paddr == DTRC_OFF_SCRATCH0);
  wire logic sel_scr1 = (paddr == DTRC_OFF_SCRATCH1);
  wire logic sel_ctrl = (paddr == DTRC_OFF_CONTROL);
  wire logic sel_cfg = (paddr == DTRC_OFF_CONFIG);
  wire logic sel_stat = (paddr == DTRC_OFF_STATUS);
  wire logic sel_any = sel_scr0 | sel_scr1 | sel_ctrl | sel_cfg | sel_stat;
  wire logic in_bg = (state_r == DTRC_BACKGROUND);
  wire logic scratch_ok = bg_debug_mode | ~in_bg;
  wire logic bp_en_wr_ok = bg_debug_mode & in_bg;
  wire logic is_debug_op = host_cmd_valid & (host_cmd_code[7:4] == DTRC_OP_PREFIX);
  wire logic op_trace = is_debug_op & (host_cmd_code[3:0] == DTRC_OP_TRACE);
  wire logic op_return = is_debug_op & (host_cmd_code[3:0] == DTRC_OP_RETURN);
  wire logic entering = in_bg & (debug_cmd_entry | break_hit);
  wire logic [7:0] ctrl_val = {bp_enable_r, 1'b0, reg_break_r, 1'b0, cmd_r};
  wire logic [31:0] stat_val = {27'h0000000, first_instr_r, gie_saved_r, ~in_bg, status_r};
  wire logic [31:0] rd_mux = sel_scr0 & scratch_ok ? {16'h0000, scratch0_r} :
                             sel_scr1 & scratch_ok ? {16'h0000, scratch1_r} :
                             sel_ctrl ? {24'h000000, ctrl_val} :
                             sel_cfg ? {31'h00000000, switchback_r} :
                             sel_stat ? stat_val : 32'h00000000;

  dtrc_bp_match u_bp_match (
    .pclk(pclk),
    .presetn(presetn),
    .bp_enable(bp_enable_r),
    .reg_break_enable(reg_break_r),
    .suppress(first_instr_r),
    .other_hit(other_bp_hit),
    .dest_wr(dest_wr),
    .dest_addr(dest_addr),
    .dest_data(dest_data),
    .address_match_breakpoint(address_match_breakpoint),
    .data_match_breakpoint(data_match_breakpoint),
    .debug_address_hold(debug_address_hold),
    .debug_data_hold(debug_data_hold),
    .break_hit(break_hit)
  );

  // Sequencer for entry, trace, return and service routine commands.
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    unique case (state_r)
      DTRC_BACKGROUND: begin
        if (entering) begin
          state_nxt = DTRC_ENTER;
        end
      end
      DTRC_ENTER: begin
        state_nxt = DTRC_DBG_IDLE;
      end
      DTRC_DBG_IDLE: begin
        if (op_trace) begin
          state_nxt = DTRC_TRACE_POP;
        end else if (op_return) begin
          state_nxt = DTRC_RET_POP;
        end else if (is_debug_op) begin
          unique case (host_cmd_code[3:0])
            DTRC_CMD_REGMAP, DTRC_CMD_MEM_RD, DTRC_CMD_STACK_RD, DTRC_CMD_REG_WR,
            DTRC_CMD_MEM_WR, DTRC_CMD_UNLOCK, DTRC_CMD_REG_RD: begin
              cmd_nxt = host_cmd_code[3:0];
              state_nxt = DTRC_ROM_BUSY;
            end
            default: begin
              cmd_nxt = DTRC_CMD_NOP;
            end
          endcase
        end
      end
      DTRC_ROM_BUSY: begin
        if (rom_done) begin
          state_nxt = DTRC_DBG_IDLE;
        end
      end
      DTRC_TRACE_POP: begin
        state_nxt = DTRC_TRACE_EXEC;
      end
      DTRC_TRACE_EXEC: begin
        if (instr_done) begin
          state_nxt = DTRC_ENTER;
        end
      end
      DTRC_RET_POP: begin
        state_nxt = DTRC_BACKGROUND;
      end
    endcase
    if (rst_s2_r) begin
      state_nxt = DTRC_BACKGROUND;
    end
  end

  always_comb begin
    unique case (state_nxt)
      DTRC_BACKGROUND: status_nxt = DTRC_ST_NON_DEBUG;
      DTRC_ENTER, DTRC_DBG_IDLE: status_nxt = DTRC_ST_IDLE;
      default: status_nxt = DTRC_ST_BUSY;
    endcase
  end

  // Reset pin passes two flip-flops before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= reset_pin;
      rst_s2_r <= rst_s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= DTRC_BACKGROUND;
      cmd_r <= DTRC_RST_CMD;
    end else begin
      state_r <= state_nxt;
      cmd_r <= rst_s2_r ? DTRC_RST_CMD : cmd_nxt;
    end
  end

  // Captured interrupt enable and first-instruction flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_saved_r <= 1'b0;
      first_instr_r <= 1'b0;
    end else begin
      if (entering) begin
        gie_saved_r <= global_interrupt_enable;
      end
      if (state_r == DTRC_RET_POP) begin
        first_instr_r <= 1'b1;
      end else if (instr_done | ~in_bg | rst_s2_r) begin
        first_instr_r <= 1'b0;
      end
    end
  end

  // CPU control outputs, registered from the next state and the current state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= DTRC_ST_NON_DEBUG;
      pop_r <= 1'b0;
      push_r <= 1'b0;
      ip_load_r <= 1'b0;
      stall_r <= 1'b0;
      fetch_block_r <= 1'b0;
      halt_r <= 1'b0;
      gie_force_r <= 1'b0;
      gie_val_r <= 1'b0;
      lpm_block_r <= 1'b0;
      timers_r <= 1'b1;
      warmup_run_r <= 1'b1;
      clk_switch_r <= 1'b0;
      div1_r <= 1'b0;
      sysclk_r <= 1'b1;
    end else begin
      status_r <= status_nxt;
      pop_r <= (state_nxt == DTRC_TRACE_POP) | (state_nxt == DTRC_RET_POP);
      push_r <= (state_nxt == DTRC_ENTER);
      ip_load_r <= (state_nxt == DTRC_ENTER) |
                   ((state_nxt == DTRC_ROM_BUSY) & (state_r == DTRC_DBG_IDLE));
      stall_r <= (state_nxt == DTRC_ENTER);
      fetch_block_r <= (state_nxt == DTRC_ENTER);
      halt_r <= (state_nxt == DTRC_ENTER) | (state_nxt == DTRC_DBG_IDLE);
      gie_force_r <= (state_nxt != DTRC_BACKGROUND) | (state_r == DTRC_RET_POP);
      gie_val_r <= ((state_nxt == DTRC_TRACE_POP) | (state_nxt == DTRC_TRACE_EXEC) |
                    (state_r == DTRC_RET_POP)) & gie_saved_r;
      lpm_block_r <= (state_r == DTRC_RET_POP) |
                     (first_instr_r & ~instr_done & in_bg);
      timers_r <= (state_nxt == DTRC_BACKGROUND);
      warmup_run_r <= 1'b1;
      clk_switch_r <= warmup_done & ~in_bg;
      div1_r <= entering & switchback_r & low_power_clock_mode;
      sysclk_r <= (state_nxt != DTRC_DBG_IDLE);
    end
  end

  // APB register file with zero wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & ~sel_any;
      if (setup_ph & ~pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch0_r <= DTRC_RST_SCRATCH;
      scratch1_r <= DTRC_RST_SCRATCH;
      bp_enable_r <= DTRC_RST_CONTROL[DTRC_BIT_BP_ENABLE];
      reg_break_r <= DTRC_RST_CONTROL[DTRC_BIT_REG_BREAK];
      switchback_r <= 1'b0;
    end else if (wr_en) begin
      if (sel_scr0 & scratch_ok) begin
        scratch0_r <= pwdata[15:0];
      end
      if (sel_scr1 & scratch_ok) begin
        scratch1_r <= pwdata[15:0];
      end
      if (sel_ctrl & bp_en_wr_ok) begin
        bp_enable_r <= pwdata[DTRC_BIT_BP_ENABLE];
      end
      if (sel_ctrl) begin
        reg_break_r <= pwdata[DTRC_BIT_REG_BREAK];
      end
      if (sel_cfg) begin
        switchback_r <= pwdata[DTRC_BIT_SWITCHBACK];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign debug_status = status_r;
  assign stack_pop = pop_r;
  assign stack_push = push_r;
  assign ip_load = ip_load_r;
  assign instruction_pointer = DTRC_ENTRY_IP;
  assign cpu_stall = stall_r;
  assign fetch_block = fetch_block_r;
  assign cpu_halt = halt_r;
  assign gie_force = gie_force_r;
  assign gie_force_value = gie_val_r;
  assign lpm_enable_block = lpm_block_r;
  assign timers_enable = timers_r;
  assign warmup_run = warmup_run_r;
  assign clk_src_switch = clk_switch_r;
  assign clk_div1_force = div1_r;
  assign sysclk_run = sysclk_r;

endmodule : dtrc_top

// ### design/dtrc_unused_guard.sv
`timescale 1ns/10ps

// ### test/dtrc_cpu_model.sv
`timescale 1ns/10ps
// Runs user code and the service routine and never touches data memory
module dtrc_cpu_model
  import dtrc_pkg::*;
(
  // Clock, reset and pacing.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] dly,
  // Engine requests.
  input wire logic stack_pop,
  input wire logic ip_load,
  input wire logic [1:0] debug_status,
  // Completion pulses.
  output logic instr_done,
  output logic rom_done
);
  logic [3:0] cnt_r;
  logic rom_r;
  // A pop runs one user instruction, a busy jump runs the service routine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      rom_r <= 1'b0;
      instr_done <= 1'b0;
      rom_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      rom_done <= 1'b0;
      if (stack_pop) begin
        cnt_r <= dly;
        rom_r <= 1'b0;
      end else if (ip_load && debug_status == DTRC_ST_BUSY) begin
        cnt_r <= dly;
        rom_r <= 1'b1;
      end else if (cnt_r == 4'h1) begin
        instr_done <= !rom_r;
        rom_done <= rom_r;
        cnt_r <= 4'h0;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule : dtrc_cpu_model

// ### test/dtrc_properties.sv
`timescale 1ns/10ps
module dtrc_properties
  import dtrc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Host side.
  input wire logic host_cmd_valid,
  input wire logic [7:0] host_cmd_code,
  input wire logic debug_cmd_entry,
  input wire logic reset_pin,
  input wire logic [1:0] debug_status,
  // CPU side.
  input wire logic instr_done,
  input wire logic global_interrupt_enable,
  input wire logic warmup_done,
  input wire logic stack_pop,
  input wire logic stack_push,
  input wire logic ip_load,
  input wire logic cpu_stall,
  input wire logic fetch_block,
  input wire logic cpu_halt,
  input wire logic gie_force,
  input wire logic gie_force_value,
  input wire logic timers_enable,
  input wire logic clk_src_switch,
  input wire logic sysclk_run
);
  logic tr_r;
  logic gie_r;
  wire idle_w = debug_status == DTRC_ST_IDLE;
  wire cmd_w = idle_w && host_cmd_valid;
  wire trace_w = cmd_w && host_cmd_code == {DTRC_OP_PREFIX, DTRC_OP_TRACE};
  wire ret_w = cmd_w && host_cmd_code == {DTRC_OP_PREFIX, DTRC_OP_RETURN};
  wire entry_w = debug_status == DTRC_ST_NON_DEBUG && debug_cmd_entry;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_r <= 1'b0;
      gie_r <= 1'b0;
    end else begin
      tr_r <= trace_w || (tr_r && !stack_push);
      gie_r <= (debug_status == DTRC_ST_NON_DEBUG) ? global_interrupt_enable : gie_r;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  trace_start_a: assert property (trace_w |=> debug_status == DTRC_ST_BUSY
    && stack_pop) else $error("trace start wrong");
  trace_end_a: assert property (tr_r && instr_done |=> stack_push && ip_load
    && cpu_stall && fetch_block && cpu_halt && idle_w) else $error("trace end wrong");
  gie_hold_a: assert property (trace_w |=> gie_force && gie_force_value == gie_r)
    else $error("saved enable not used");
  return_seq_a: assert property (ret_w |=> stack_pop ##1
    debug_status == DTRC_ST_NON_DEBUG && timers_enable) else $error("return wrong");
  entry_push_a: assert property (entry_w |=> idle_w && stack_push && ip_load
    && cpu_halt && gie_force && !gie_force_value) else $error("entry wrong");
  idle_stop_a: assert property (idle_w && $past(idle_w) && !reset_pin
    |-> !sysclk_run && !timers_enable) else $error("clock or timers run in idle");
  warmup_switch_a: assert property (!debug_status[1] && idle_w && warmup_done
    |=> clk_src_switch) else $error("no clock switch");
  pop_busy_a: assert property (stack_pop |-> debug_status == DTRC_ST_BUSY
    && !cpu_halt) else $error("pop while not busy");
endmodule : dtrc_properties
bind dtrc_top dtrc_properties u_props (.*);

// ### test/tb.sv
`timescale 1ns/10ps
module tb
  import dtrc_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, host_cmd_valid, debug_cmd_entry;
  logic bg_debug_mode, rom_done, reset_pin, instr_done, global_interrupt_enable;
  logic low_power_clock_mode, warmup_done, dest_wr, other_bp_hit, pready, pslverr;
  logic stack_pop, stack_push, ip_load, cpu_stall, fetch_block, cpu_halt, gie_force;
  logic gie_force_value, lpm_enable_block, timers_enable, warmup_run, clk_src_switch;
  logic clk_div1_force, sysclk_run, perr;
  logic [7:0] paddr, host_cmd_code;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] debug_status;
  logic [15:0] instruction_pointer, dest_addr, dest_data, address_match_breakpoint;
  logic [15:0] data_match_breakpoint, debug_address_hold, debug_data_hold;
  logic [3:0] dly;
  int err_total, samples_checked, cyc;
  dtrc_top uut (.*);
  dtrc_cpu_model u_cpu (.*);
  always #25 pclk = ~pclk;
  task automatic give_verdict;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd
  task automatic wst(input logic [1:0] s);
    while (debug_status !== s) begin
      @(posedge pclk);
    end
  endtask : wst
  task automatic cmd(input logic [3:0] c);
    repeat (8) @(posedge pclk);
    host_cmd_valid <= 1'b1;
    host_cmd_code <= {DTRC_OP_PREFIX, c};
    @(posedge pclk);
    host_cmd_valid <= 1'b0;
    @(negedge pclk);
  endtask : cmd
  task automatic wdone;
    while (instr_done !== 1'b1) begin
      @(posedge pclk);
    end
    @(negedge pclk);
  endtask : wdone
  task automatic dest(input logic [15:0] a, input logic [15:0] d, input logic [1:0] s);
    @(posedge pclk);
    dest_wr <= 1'b1;
    dest_addr <= a;
    dest_data <= d;
    @(posedge pclk);
    dest_wr <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(debug_status, s);
  endtask : dest
  task automatic t_regs;
    rd(DTRC_OFF_SCRATCH1, 32'h0);
    apb(1'b1, DTRC_OFF_SCRATCH0, 32'h1234);
    rd(DTRC_OFF_SCRATCH0, 32'h0);
    apb(1'b1, DTRC_OFF_CONTROL, 32'h80);
    rd(DTRC_OFF_CONTROL, 32'h0);
    bg_debug_mode <= 1'b1;
    apb(1'b1, DTRC_OFF_SCRATCH1, 32'hffffbeef);
    apb(1'b1, DTRC_OFF_CONTROL, 32'hff);
    apb(1'b1, DTRC_OFF_CONFIG, 32'h1);
    rd(DTRC_OFF_SCRATCH1, 32'hbeef);
    rd(DTRC_OFF_CONTROL, 32'ha0);
    rd(DTRC_OFF_CONFIG, 32'h1);
    rd(8'h20, 32'h0);
    chk(perr, 1'b1);
  endtask : t_regs
  task automatic t_enter;
    low_power_clock_mode <= 1'b1;
    global_interrupt_enable <= 1'b1;
    debug_cmd_entry <= 1'b1;
    @(posedge pclk);
    debug_cmd_entry <= 1'b0;
    @(negedge pclk);
    chk(clk_div1_force, 1'b1);
    chk({stack_push, debug_status}, {1'b1, DTRC_ST_IDLE});
    @(posedge pclk);
    global_interrupt_enable <= 1'b0;
    bg_debug_mode <= 1'b0;
    warmup_done <= 1'b1;
    @(posedge pclk);
    warmup_done <= 1'b0;
    @(negedge pclk);
    chk({clk_src_switch, sysclk_run, warmup_run}, 3'h5);
    apb(1'b1, DTRC_OFF_SCRATCH0, 32'h0f0f);
    rd(DTRC_OFF_SCRATCH0, 32'h0f0f);
    rd(DTRC_OFF_STATUS, 32'hd);
  endtask : t_enter
  task automatic t_cmds;
    logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha};
    foreach (codes[i]) begin
      dly <= codes[i] + 4'h1;
      cmd(codes[i]);
      wst(DTRC_ST_IDLE);
      rd(DTRC_OFF_CONTROL, {24'h0, 4'ha, codes[i] == 4'ha ? 4'h0 : codes[i]});
    end
    dly <= 4'hc;
  endtask : t_cmds
  task automatic t_trace;
    cmd(DTRC_OP_TRACE);
    chk({debug_status, stack_pop}, {DTRC_ST_BUSY, 1'b1});
    chk(gie_force_value, 1'b1);
    wst(DTRC_ST_IDLE);
    chk({cpu_halt, gie_force_value, stack_push}, 3'h5);
    chk(instruction_pointer, DTRC_ENTRY_IP);
  endtask : t_trace
  task automatic t_return;
    cmd(DTRC_OP_RETURN);
    wst(DTRC_ST_NON_DEBUG);
    chk({timers_enable, lpm_enable_block}, 2'h3);
    chk({gie_force, gie_force_value}, 2'h3);
    dest(16'h0042, 16'h0, DTRC_ST_NON_DEBUG);
    wdone();
    chk(lpm_enable_block, 1'b0);
    dest(16'h0042, 16'h0, DTRC_ST_IDLE);
    cmd(DTRC_OP_RETURN);
    wdone();
    dest(16'h0050, 16'hab13, DTRC_ST_NON_DEBUG);
    dest(16'h0050, 16'hab12, DTRC_ST_IDLE);
  endtask : t_return
  task automatic t_pin;
    reset_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(debug_status, DTRC_ST_IDLE);
    @(posedge pclk);
    chk(debug_status, DTRC_ST_NON_DEBUG);
    reset_pin <= 1'b0;
  endtask : t_pin
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, host_cmd_valid, debug_cmd_entry, bg_debug_mode, reset_pin,
      global_interrupt_enable, low_power_clock_mode, warmup_done, dest_wr, other_bp_hit} = '0;
    {paddr, host_cmd_code, pwdata, dest_addr, dest_data} = '0;
    address_match_breakpoint = 16'h0042;
    data_match_breakpoint = 16'h0050;
    debug_address_hold = 16'h00ff;
    debug_data_hold = 16'h0012;
    dly = 4'h3;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(timers_enable, 1'b1);
    t_regs();
    t_enter();
    t_cmds();
    t_trace();
    t_return();
    t_pin();
    give_verdict();
  end
endmodule : tb
